// >>> design/video_sync_params.svh
/*
  Register offsets, field positions, reset values and timing-reference code
  words for the sync pin select block.
  Assumes 8-bit register offsets on the plain register port.
*/
`ifndef VIDEO_SYNC_PARAMS_SVH
`define VIDEO_SYNC_PARAMS_SVH

`define REG_SYNC_OUT      8'h02
`define REG_EDHD_INFMT    8'h30
`define REG_EDHD_SYNCCTL  8'h34
`define REG_SD_SLAVE      8'h8A
`define REG_STANDARD      8'hF0
`define REG_STATUS        8'hF1

`define RST_SYNC_OUT      8'h00
`define RST_EDHD_INFMT    8'h00
`define RST_EDHD_SYNCCTL  8'h00
`define RST_SD_SLAVE      8'h00
`define RST_STANDARD      8'h00
`define READ_IDLE         8'h00

`define BIT_EDHD_OUT_EN   7
`define BIT_SD_OUT_EN     6
`define BIT_INFMT         2
`define BIT_HCTL          1
`define BIT_VCTL          2
`define SLAVE_MSB         2
`define SLAVE_LSB         0
`define SLAVE_MODE_OFF    3'h0
`define SLAVE_MODE_MAX    3'h3
`define BIT_STD_EDHD_INTL 0
`define BIT_STD_525P      1
`define BIT_STD_SD_INTL   2

`define TRS_ONES          10'h3FF
`define TRS_ZERO          10'h000
`define TRS_BIT_F         8
`define TRS_BIT_V         7
`define TRS_BIT_H         6
`define HCNT_AFTER_EDGE   1'b1

`endif

// >>> design/video_sync_pkg.sv
/*
  Types shared by the sync pin select block.
  Assumes video_sync_params.svh supplies the numeric constants.
*/
package video_sync_pkg;

  typedef enum logic [1:0] {
    TRS_IDLE = 2'b00,
    TRS_ONES = 2'b01,
    TRS_Z1   = 2'b10,
    TRS_Z2   = 2'b11
  } trs_state_e;

  typedef struct packed {
    logic f;
    logic v;
    logic h;
  } trs_flags_s;

  typedef struct packed {
    logic hsyncN;
    logic vsyncN;
    logic driveN;
  } sync_pins_s;

endpackage

// >>> design/sync_delay_line.sv
/*
  Fixed-length register pipeline for the sync pin bundle.
  Assumes DEPTH of at least one; every stage holds while ce is low.
*/
`timescale 1ns/1ps
module sync_delay_line #(
  parameter int               WIDTH  = 3,
  parameter int               DEPTH  = 8,
  parameter logic [WIDTH-1:0] RSTVAL = '1
) (
  // Clock and control
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             ce,
  // Data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage_q [DEPTH];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_stage
      always_ff @(posedge clock)
      begin
        if (!nrst)
          stage_q[i] <= RSTVAL;
        else if (ce)
          stage_q[i] <= (i == 0) ? din : stage_q[(i == 0) ? 0 : i - 1];
      end
    end
  endgenerate

  assign dout = stage_q[DEPTH-1];

endmodule // sync_delay_line

// >>> design/video_sync_pin_io_select.sv
/*
  Sync pin select: takes horizontal/vertical timing from embedded codes or
  sync pins, and drives SD or ED/HD sync on the shared sync pins.
  Assumes one pixel clock, pins arriving asynchronously, SD sync from the SD
  timing core on the same clock, and a register master on the same clock.
*/
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "video_sync_params.svh"
module video_sync_pin_io_select
  import video_sync_pkg::*;
#(
  parameter int         PIPE_DELAY   = 8,
  parameter int         HCNT_W       = 12,
  parameter int         VCNT_W       = 11,
  parameter logic [11:0] LINE_PIXELS  = 12'h6B4,
  parameter logic [11:0] HSYNC_PIXELS = 12'h040,
  parameter logic [10:0] FRAME_LINES  = 11'h20D,
  parameter logic [10:0] VBLANK_LINES = 11'h02D,
  parameter logic [10:0] VS_FIRST     = 11'h004,
  parameter logic [10:0] VS_LINES     = 11'h005
) (
  // Clock, reset, enable
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        ce,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdata,
  // Pixel stream carrying timing codes
  input  wire logic [9:0]  pixelIn,
  // ED/HD sync and blank pins
  input  wire logic        pHsyncN,
  input  wire logic        pVsyncN,
  input  wire logic        pBlankN,
  // Shared SD sync pins
  input  wire logic        sHsyncIn,
  input  wire logic        sVsyncIn,
  output logic             sHsyncOut,
  output logic             sHsyncOeN,
  output logic             sVsyncOut,
  output logic             sVsyncOeN,
  // SD timing core
  input  wire logic        sdHsyncN,
  input  wire logic        sdVsyncN,
  output logic             sdSlavePinsUse,
  output logic             sdSlaveHsyncN,
  output logic             sdSlaveVsyncN,
  // ED/HD timing core
  output logic             edhdPinTiming,
  output logic             edhdHsyncInN,
  output logic             edhdVsyncInN,
  output logic             edhdBlankInN
);

  logic [7:0]  syncOut_q, inFmt_q, syncCtl_q, sdSlave_q, standard_q, rdata_q;
  logic [4:0]  pin1_q, pin2_q;
  logic [9:0]  pix1_q, pix2_q;
  trs_state_e  trs_q, trs_d;
  trs_flags_s  trsFlags_q;
  logic        trsH_q, trsV_q;
  logic [HCNT_W-1:0] hCount_q;
  logic [VCNT_W-1:0] vCount_q;
  logic        sdUse_q, edhdPin_q, sdH_q, sdV_q, edH_q, edV_q, edB_q;
  sync_pins_s  selPins, outPins;

  // Register decode
  wire wrSyncOut  = regWr && (regAddr == `REG_SYNC_OUT);
  wire wrInFmt    = regWr && (regAddr == `REG_EDHD_INFMT);
  wire wrSyncCtl  = regWr && (regAddr == `REG_EDHD_SYNCCTL);
  wire wrSdSlave  = regWr && (regAddr == `REG_SD_SLAVE);
  wire wrStandard = regWr && (regAddr == `REG_STANDARD);

  wire edhdOutEn  = syncOut_q[`BIT_EDHD_OUT_EN];
  wire sdOutEn    = syncOut_q[`BIT_SD_OUT_EN];
  wire fmtCodes   = inFmt_q[`BIT_INFMT];
  wire hCtl       = syncCtl_q[`BIT_HCTL];
  wire vCtl       = syncCtl_q[`BIT_VCTL];
  wire edhdIntl   = standard_q[`BIT_STD_EDHD_INTL];
  wire is525p     = standard_q[`BIT_STD_525P];
  wire sdIntl     = standard_q[`BIT_STD_SD_INTL];
  wire [2:0] slaveMode = sdSlave_q[`SLAVE_MSB:`SLAVE_LSB];

  wire [7:0] statusWord = {1'b0, trsFlags_q.f, trsFlags_q.v, trsFlags_q.h,
                           ~outPins.driveN, edhdPin_q, sdUse_q, 1'b0};

  wire [7:0] readMux =
    (regAddr == `REG_SYNC_OUT)     ? syncOut_q  :
    (regAddr == `REG_EDHD_INFMT)   ? inFmt_q    :
    (regAddr == `REG_EDHD_SYNCCTL) ? syncCtl_q  :
    (regAddr == `REG_SD_SLAVE)     ? sdSlave_q  :
    (regAddr == `REG_STANDARD)     ? standard_q :
    (regAddr == `REG_STATUS)       ? statusWord : `READ_IDLE;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      syncOut_q  <= `RST_SYNC_OUT;
      inFmt_q    <= `RST_EDHD_INFMT;
      syncCtl_q  <= `RST_EDHD_SYNCCTL;
      sdSlave_q  <= `RST_SD_SLAVE;
      standard_q <= `RST_STANDARD;
      rdata_q    <= `READ_IDLE;
    end
    else if (ce)
    begin
      if (wrSyncOut)
        syncOut_q <= regWdata;
      if (wrInFmt)
        inFmt_q <= regWdata;
      if (wrSyncCtl)
        syncCtl_q <= regWdata;
      if (wrSdSlave)
        sdSlave_q <= regWdata;
      if (wrStandard)
        standard_q <= regWdata;
      // Read data stands for exactly the cycle after the strobe
      rdata_q <= regRd ? readMux : `READ_IDLE;
    end
  end

  assign regRdata = rdata_q;

  // Two-flop synchronisers for pins; first stage feeds only the second
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      pin1_q <= '1;
      pin2_q <= '1;
      pix1_q <= `TRS_ZERO;
      pix2_q <= `TRS_ZERO;
    end
    else if (ce)
    begin
      pin1_q <= {pBlankN, pVsyncN, pHsyncN, sVsyncIn, sHsyncIn};
      pin2_q <= pin1_q;
      pix1_q <= pixelIn;
      pix2_q <= pix1_q;
    end
  end

  wire sHsyncSync = pin2_q[0];
  wire sVsyncSync = pin2_q[1];
  wire pHsyncSync = pin2_q[2];
  wire pVsyncSync = pin2_q[3];
  wire pBlankSync = pin2_q[4];

  // Timing reference code search: ones, zero, zero, then flag word
  wire pixOnes = (pix2_q == `TRS_ONES);
  wire pixZero = (pix2_q == `TRS_ZERO);

  always_comb
  begin
    case (trs_q)
      TRS_IDLE: trs_d = pixOnes ? TRS_ONES : TRS_IDLE;
      TRS_ONES: trs_d = pixZero ? TRS_Z1 : (pixOnes ? TRS_ONES : TRS_IDLE);
      TRS_Z1:   trs_d = pixZero ? TRS_Z2 : TRS_IDLE;
      TRS_Z2:   trs_d = TRS_IDLE;
      default:  trs_d = TRS_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      trs_q      <= TRS_IDLE;
      trsFlags_q <= '0;
      trsH_q     <= 1'b0;
      trsV_q     <= 1'b0;
    end
    else if (ce)
    begin
      trs_q  <= trs_d;
      trsH_q <= trsFlags_q.h;
      trsV_q <= trsFlags_q.v;
      if (trs_q == TRS_Z2)
        trsFlags_q <= '{f: pix2_q[`TRS_BIT_F], v: pix2_q[`TRS_BIT_V], h: pix2_q[`TRS_BIT_H]};
    end
  end

  // Leading edges of embedded blanking phase the internal counters
  wire hEdge = trsFlags_q.h && !trsH_q;
  wire vEdge = trsFlags_q.v && !trsV_q;
  wire lineEnd  = (hCount_q == HCNT_W'(LINE_PIXELS - 12'h001));
  wire frameEnd = (vCount_q == VCNT_W'(FRAME_LINES - 11'h001));

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      hCount_q <= '0;
      vCount_q <= '0;
    end
    else if (ce)
    begin
      // Edge cycle counts as pixel 0, so the counter pulse starts with the
      // embedded sync instead of one pixel late
      if (hEdge)
        hCount_q <= HCNT_W'(`HCNT_AFTER_EDGE);
      else if (lineEnd)
        hCount_q <= '0;
      else
        hCount_q <= hCount_q + 1'b1;
      if (vEdge)
        vCount_q <= '0;
      else if (lineEnd)
        vCount_q <= frameEnd ? '0 : vCount_q + 1'b1;
    end
  end

  // Counter sync width is HSYNC_PIXELS pixels, set independently of the embedded hsync width
  wire cntHsync = (hCount_q < HCNT_W'(HSYNC_PIXELS));
  wire cntVsBlank = (vCount_q < VCNT_W'(VBLANK_LINES));
  wire cntVsSerr  = (vCount_q >= VCNT_W'(VS_FIRST)) &&
                    (vCount_q < VCNT_W'(VS_FIRST + VS_LINES));
  wire cntVsync = is525p ? cntVsBlank : cntVsSerr;

  // Selected ED/HD sources, active low on the pins
  wire edhdHsel = hCtl     ? ~cntHsync :
                  fmtCodes ? ~trsFlags_q.h :
                             pHsyncSync;
  wire edhdCodeV = edhdIntl ? trsFlags_q.f :
                              ~trsFlags_q.v;
  wire edhdVsel = vCtl     ? ~cntVsync :
                  fmtCodes ? edhdCodeV :
                             pVsyncSync;
  // SD progressive has no vertical output defined; hold it inactive
  wire sdVsel   = sdIntl ? sdVsyncN : 1'b1;

  always_comb
  begin
    selPins.driveN = !(edhdOutEn || sdOutEn);
    if (edhdOutEn)
    begin
      selPins.hsyncN = edhdHsel;
      selPins.vsyncN = edhdVsel;
    end
    else if (sdOutEn)
    begin
      selPins.hsyncN = sdHsyncN;
      selPins.vsyncN = sdVsel;
    end
    else
    begin
      selPins.hsyncN = 1'b1;
      selPins.vsyncN = 1'b1;
    end
  end

  // Matches video datapath latency so sync edges track the output video
  sync_delay_line #(
    .WIDTH  (3),
    .DEPTH  (PIPE_DELAY),
    .RSTVAL (3'h7)
  ) u_delay (
    .clock (clock),
    .nrst  (nrst),
    .ce    (ce),
    .din   (selPins),
    .dout  (outPins)
  );

  assign sHsyncOut = outPins.hsyncN;
  assign sVsyncOut = outPins.vsyncN;
  assign sHsyncOeN = outPins.driveN;
  assign sVsyncOeN = outPins.driveN;

  // Pin inputs towards the timing cores
  wire slaveSel = (slaveMode != `SLAVE_MODE_OFF) && (slaveMode <= `SLAVE_MODE_MAX);
  // Uses the register enables, not the delayed pins: the device stops
  // listening as soon as software turns an output on
  wire sdPinsIn = slaveSel && !edhdOutEn && !sdOutEn;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      sdUse_q   <= 1'b0;
      edhdPin_q <= 1'b1;
      sdH_q     <= 1'b1;
      sdV_q     <= 1'b1;
      edH_q     <= 1'b1;
      edV_q     <= 1'b1;
      edB_q     <= 1'b1;
    end
    else if (ce)
    begin
      sdUse_q   <= sdPinsIn;
      sdH_q     <= sdPinsIn ? sHsyncSync : 1'b1;
      sdV_q     <= sdPinsIn ? sVsyncSync : 1'b1;
      edhdPin_q <= !fmtCodes;
      edH_q     <= fmtCodes ? 1'b1 : pHsyncSync;
      edV_q     <= fmtCodes ? 1'b1 : pVsyncSync;
      edB_q     <= pBlankSync;
    end
  end

  assign sdSlavePinsUse = sdUse_q;
  assign sdSlaveHsyncN  = sdH_q;
  assign sdSlaveVsyncN  = sdV_q;
  assign edhdPinTiming  = edhdPin_q;
  assign edhdHsyncInN   = edH_q;
  assign edhdVsyncInN   = edV_q;
  assign edhdBlankInN   = edB_q;

endmodule // video_sync_pin_io_select

// >>> dv/video_sync_chk.sv
/* Checker for the sync pin select block, bound to its ports.
   Assumes ce held high and PIPE_DELAY of at least 2. */
`timescale 1ns/1ps
module video_sync_chk #(
  parameter int PIPE_DELAY = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  // Pins and cores
  input wire logic pHsyncN,
  input wire logic pVsyncN,
  input wire logic sHsyncIn,
  input wire logic sHsyncOut,
  input wire logic sHsyncOeN,
  input wire logic sVsyncOut,
  input wire logic sVsyncOeN,
  input wire logic sdHsyncN,
  input wire logic sdSlavePinsUse,
  input wire logic sdSlaveHsyncN,
  input wire logic edhdPinTiming
);
  logic [7:0] syncOut_q;
  logic fmt_q;
  logic [1:0] ctl_q;
  logic [2:0] slave_q;
  logic [5*PIPE_DELAY-1:0] modeSh_q;
  logic [4:0] mode;
  // Mode leaving the pipeline: ED/HD en, SD en, format, vsync ctl, hsync ctl
  assign mode = modeSh_q[5*PIPE_DELAY-1 -: 5];
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      syncOut_q <= 8'h00;
      fmt_q <= 1'b0;
      ctl_q <= 2'h0;
      slave_q <= 3'h0;
      modeSh_q <= '0;
    end
    else
    begin
      if (regWr && regAddr == 8'h02)
        syncOut_q <= regWdata;
      if (regWr && regAddr == 8'h30)
        fmt_q <= regWdata[2];
      if (regWr && regAddr == 8'h34)
        ctl_q <= regWdata[2:1];
      if (regWr && regAddr == 8'h8A)
        slave_q <= regWdata[2:0];
      modeSh_q <= {modeSh_q[5*PIPE_DELAY-6:0], syncOut_q[7:6], fmt_q, ctl_q};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_slave; sdSlavePinsUse == $past(syncOut_q[7:6] == 2'h0 && slave_q != 3'h0 && !slave_q[2]); endproperty
  a_slave: assert property (p_slave) else $error("slave pin use wrong");
  property p_fmt; edhdPinTiming == $past(!fmt_q); endproperty
  a_fmt: assert property (p_fmt) else $error("pin timing select wrong");
  property p_oe; {sHsyncOeN, sVsyncOeN} == {2{mode[4:3] == 2'h0}}; endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");
  property p_idle; sHsyncOeN |-> sHsyncOut && sVsyncOut; endproperty
  a_idle: assert property (p_idle) else $error("released pins not idle");
  property p_sd; mode[4:3] == 2'h1 |-> sHsyncOut == $past(sdHsyncN, PIPE_DELAY); endproperty
  a_sd: assert property (p_sd) else $error("SD hsync not pipelined");
  property p_hpin; mode[4] && !mode[2] && !mode[0] |-> sHsyncOut == $past(pHsyncN, PIPE_DELAY + 2); endproperty
  a_hpin: assert property (p_hpin) else $error("hsync pin copy wrong");
  property p_vpin; mode[4] && !mode[2] && !mode[1] |-> sVsyncOut == $past(pVsyncN, PIPE_DELAY + 2); endproperty
  a_vpin: assert property (p_vpin) else $error("vsync pin copy wrong");
  property p_slvpin; sdSlaveHsyncN == (sdSlavePinsUse ? $past(sHsyncIn, 3) : 1'b1); endproperty
  a_slvpin: assert property (p_slvpin) else $error("slave hsync wrong");
  property p_rd; regRd && regAddr == 8'h02 |=> regRdata == syncOut_q; endproperty
  a_rd: assert property (p_rd) else $error("readback wrong");
  c_sd: cover property (mode[4:3] == 2'h1);
  c_edhd: cover property (mode[4] && mode[2]);
  c_slave: cover property (sdSlavePinsUse);
endmodule // video_sync_chk

bind video_sync_pin_io_select video_sync_chk #(.PIPE_DELAY(PIPE_DELAY)) chk (.*);

// >>> dv/video_source.sv
/* Upstream video source: timing as embedded codes and as pins.
   Assumes a 32-pixel line and a 20-line frame of two fields. */
`timescale 1ns/1ps
module video_source (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Timing to the encoder
  output logic [9:0] pixelIn,
  output logic pHsyncN,
  output logic pVsyncN,
  output logic pBlankN
);
  logic [4:0] pix_q;
  logic [4:0] line_q;
  logic [9:0] code;
  // Flags: F in second field, V in first three lines, H in first half line
  assign code = {1'b1, line_q >= 5'h0A, line_q < 5'h03, pix_q < 5'h10, 6'h00};
  // Codes at pixels 0-3 and 16-19; filler never forms 3FF or 000
  assign pixelIn = pix_q[3:2] != 2'h0 ? {5'h08, pix_q} : pix_q[1:0] == 2'h0 ? 10'h3FF :
                   pix_q[1:0] == 2'h3 ? code : 10'h000;
  assign pHsyncN = pix_q >= 5'h06;
  assign pVsyncN = line_q != 5'h01 && line_q != 5'h02;
  assign pBlankN = pix_q >= 5'h10;
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      pix_q <= 5'h00;
      line_q <= 5'h00;
    end
    else
    begin
      pix_q <= pix_q + 5'h01;
      if (pix_q == 5'h1F)
        line_q <= line_q == 5'h13 ? 5'h00 : line_q + 5'h01;
    end
  end
endmodule // video_source

// >>> dv/tb.sv
/* Self-checking bench for the sync pin select block.
   Assumes the source model and the bound checker. */
`timescale 1ns/1ps
module tb;
  localparam int PD = 2;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic sdHsyncN = 1'b1;
  logic sdVsyncN = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic [9:0] pixelIn;
  logic pHsyncN, pVsyncN, pBlankN, sHsyncIn, sVsyncIn, sHsyncOut, sHsyncOeN, sVsyncOut, sVsyncOeN;
  logic sdSlavePinsUse, sdSlaveHsyncN, sdSlaveVsyncN;
  logic edhdPinTiming, edhdHsyncInN, edhdVsyncInN, edhdBlankInN;
  logic [3:0] pq [$];
  int cyc = 0;
  int hFall [6];
  int vFall [6];
  logic [31:0] seed = 32'h0000001A;
  logic [1:0] sdQ [$];
  logic [7:0] regs [5] = '{8'h02, 8'h30, 8'h34, 8'h8A, 8'hF0};
  int failures = 0;
  int checks = 0;
  // The shared pins carry the source's level whenever the encoder lets go
  assign sHsyncIn = sHsyncOeN ? pHsyncN : sHsyncOut;
  assign sVsyncIn = sVsyncOeN ? pVsyncN : sVsyncOut;
  always #20 clock = ~clock;
  video_source src (.*);
  video_sync_pin_io_select #(.PIPE_DELAY(PD), .LINE_PIXELS(12'h020), .HSYNC_PIXELS(12'h004),
    .FRAME_LINES(11'h014), .VBLANK_LINES(11'h005), .VS_FIRST(11'h001), .VS_LINES(11'h004))
    uut (.*);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // SD core sync is random; its history is the pipeline model
  always @(posedge clock)
  begin
    sdQ.push_front({sdHsyncN, sdVsyncN});
    if (sdQ.size() > 4)
      sdQ.delete(4);
    // Pin history: ED/HD hsync, vsync, blank and the SD vsync pin
    pq.push_front({pHsyncN, pVsyncN, pBlankN, sVsyncIn});
    if (pq.size() > 4)
      pq.delete(4);
    cyc <= cyc + 1;
    seed = xs(seed);
    sdHsyncN <= seed[3];
    sdVsyncN <= seed[9];
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    #1 chk(regRdata, e);
  endtask
  // Low cycles over one whole frame do not depend on where the window starts
  task automatic duty(input logic [7:0] f, input logic [7:0] c, input logic [7:0] s,
                      input logic [15:0] eh, input logic [15:0] ev, output int hf, output int vf);
    logic [15:0] nh;
    logic [15:0] nv;
    logic ph;
    logic pv;
    wr(8'h30, f);
    wr(8'h34, c);
    wr(8'hF0, s);
    nh = 16'h0000;
    nv = 16'h0000;
    ph = 1'b0;
    pv = 1'b0;
    hf = -1;
    vf = -1;
    repeat (700) @(posedge clock);
    repeat (640)
    begin
      @(posedge clock);
      nh += {15'h0000, ~sHsyncOut};
      nv += {15'h0000, ~sVsyncOut};
      // Phase of the falling edges within the line and the frame
      if (ph && !sHsyncOut)
        hf = cyc % 32;
      if (pv && !sVsyncOut)
        vf = cyc % 640;
      ph = sHsyncOut;
      pv = sVsyncOut;
    end
    chk(nh, eh);
    chk(nv, ev);
  endtask
  task automatic sdrun(input logic intl);
    repeat (PD + 3) @(posedge clock);
    repeat (30)
    begin
      @(posedge clock);
      #1 chk({sHsyncOut, sVsyncOut}, {sdQ[PD-1][1], intl ? sdQ[PD-1][0] : 1'b1});
    end
  endtask
  // ED/HD pin inputs pass two sync flops and one output flop
  task automatic pins(input logic fm);
    repeat (40)
    begin
      @(posedge clock);
      #1 chk({edhdPinTiming, edhdHsyncInN, edhdVsyncInN, edhdBlankInN},
             {~fm, fm | pq[2][3], fm | pq[2][2], pq[2][1]});
    end
  endtask
  task automatic test_done;
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    logic [7:0] d;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    foreach (regs[i])
    begin
      d = seed[7:0];
      rd(regs[i], 8'h00);
      wr(regs[i], d);
      rd(regs[i], d);
    end
    wr(8'h55, 8'hA5);
    rd(8'h55, 8'h00);
    wr(8'h8A, 8'h00);
    wr(8'h02, 8'h80);
    duty(8'h00, 8'h00, 8'h00, 16'h0078, 16'h0040, hFall[0], vFall[0]);
    pins(1'b0);
    wr(8'h02, 8'hC0);
    duty(8'h00, 8'h00, 8'h00, 16'h0078, 16'h0040, hFall[1], vFall[1]);
    duty(8'h04, 8'h00, 8'h01, 16'h0140, 16'h0140, hFall[2], vFall[2]);
    pins(1'b1);
    duty(8'h04, 8'h00, 8'h00, 16'h0140, 16'h0060, hFall[3], vFall[3]);
    duty(8'h04, 8'h06, 8'h00, 16'h0050, 16'h0080, hFall[4], vFall[4]);
    duty(8'h00, 8'h06, 8'h02, 16'h0050, 16'h00A0, hFall[5], vFall[5]);
    // Counter pulses must start where the embedded-code pulses start
    chk(16'(hFall[4]), 16'(hFall[3]));
    chk(16'(vFall[5]), 16'(vFall[3]));
    wr(8'h02, 8'h40);
    wr(8'hF0, 8'h04);
    sdrun(1'b1);
    chk({sHsyncOeN, sVsyncOeN}, 2'h0);
    wr(8'hF0, 8'h00);
    sdrun(1'b0);
    wr(8'h02, 8'h00);
    for (int m = 7; m >= 0; m--)
    begin
      wr(8'h8A, 8'(m + 1));
      repeat (PD + 3) @(posedge clock);
      chk({sHsyncOeN, sVsyncOeN, sHsyncOut, sVsyncOut}, 4'hF);
      chk(sdSlavePinsUse, m < 3);
      #1 chk(sdSlaveVsyncN, (m < 3) ? pq[2][0] : 1'b1);
    end
    wr(8'h02, 8'h40);
    repeat (PD + 3) @(posedge clock);
    chk(sdSlavePinsUse, 1'b0);
    wr(8'h02, 8'h80);
    repeat (PD + 3) @(posedge clock);
    chk(sdSlavePinsUse, 1'b0);
    test_done();
  end
endmodule // tb
